/* prl_pkg.sv */
/*
 holds the constants, modes and carrier structs of the port rate limiter.
 assumes one 10 MHz switch clock and a synchronous active-high reset.
*/
// What this block does
// - ingress low register keeps the priority 1 code in bits 14:8 and priority 0 in bits 6:0.
// - ingress high register keeps the priority 3 code in bits 14:8 and priority 2 in bits 6:0.
// - egress low register keeps the priority 1 code in bits 14:8 and priority 0 in bits 6:0.
// - bit 7 of the egress low register turns egress limiting on, resetting to zero.
// - code zero, the reset value of every field, means no limiting at full line rate.
// - at 100 Mbit/s codes 1 to 100 permit 1 to 100 Mbit/s in 1 Mbit/s steps.
// - at 10 Mbit/s codes 1 to 10 permit 1 to 10 Mbit/s in 1 Mbit/s steps.
// - at 100 Mbit/s codes 0x65 to 0x73 permit 64 to 960 Kbit/s in 64 Kbit/s steps.
// - frames over the permitted rate of their priority and direction are dropped.
// - a two-bit ingress mode picks which frame kinds are counted and limited.
// - with gap counting on, twelve bytes per frame join the rate byte count.
// - with preamble counting on, eight bytes per frame join the rate byte count.
// - egress high register keeps the priority 3 code in bits 14:8 and priority 2 in bits 6:0.
package prl_pkg;
   // ****************************************************
   // timing
   // ****************************************************
   localparam int unsigned CLK_MHZ = 10;
   localparam int unsigned TICK_US = 125;
   localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
   localparam int unsigned SUB_KBPS = 64;
   localparam int unsigned MBPS_BITS = TICK_US;
   localparam int unsigned SUB_BITS = SUB_KBPS * TICK_US / 1000;
   // ****************************************************
   // register indices (byte address is four times)
   // ****************************************************
   localparam logic [11:0] IDX_CTRL = 12'h072;
   localparam logic [11:0] IDX_ING_LO = 12'h074;
   localparam logic [11:0] IDX_ING_HI = 12'h076;
   localparam logic [11:0] IDX_EGR_LO = 12'h078;
   localparam logic [11:0] IDX_EGR_HI = 12'h07a;
   localparam int unsigned IDX_LSB = 2;
   // ****************************************************
   // fields and codes
   // ****************************************************
   localparam int unsigned CODE_W = 7;
   localparam int unsigned HI_LSB = 8;
   localparam int unsigned LO_LSB = 0;
   localparam int unsigned EGR_EN_BIT = 7;
   localparam int unsigned MODE_LSB = 2;
   localparam int unsigned IFG_BIT = 1;
   localparam int unsigned PRE_BIT = 0;
   localparam logic [6:0] CODE_OFF = 7'h00;
   localparam logic [6:0] CODE_MBPS_MAX = 7'h64;
   localparam logic [6:0] CODE_10M_MAX = 7'h0a;
   localparam logic [6:0] CODE_SUB_MIN = 7'h65;
   localparam logic [6:0] CODE_SUB_MAX = 7'h73;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [4:0] IFG_BYTES = 5'h0c;
   localparam logic [4:0] PRE_BYTES = 5'h08;
   localparam int unsigned NUM_PRIO = 4;
   localparam int unsigned NUM_BKT = 8;
   typedef enum logic [1:0] {
      LIM_ALL = 2'h0,
      LIM_BMF = 2'h1,
      LIM_BM = 2'h2,
      LIM_B = 2'h3
   } prl_mode_e;
   typedef struct packed {
      logic valid;
      logic [1:0] prio;
      logic [11:0] len;
      logic bcast;
      logic mcast;
      logic flood;
   } prl_frame_s;
   typedef struct packed {
      logic valid;
      logic pass;
      logic metered;
   } prl_verdict_s;
endpackage

/* prl_rate_limit.sv */
/*
 per-port rate limit registers on apb and the credit meters they steer.
 assumes the datapath offers one frame descriptor per direction and obeys
 the verdict returned one cycle later.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module prl_rate_limit
   import prl_pkg::*;
#(
   parameter int unsigned ADDR_W = 14,
   parameter int unsigned BURST_BYTES = 2048,
   parameter int unsigned CRED_W = 20
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic speed_100,
   input wire prl_frame_s ing_frame,
   input wire prl_frame_s egr_frame,
   output prl_verdict_s ing_verdict,
   output prl_verdict_s egr_verdict
);
   // ****************************************************
   // helpers
   // ****************************************************
   localparam logic [CRED_W-1:0] CAP = CRED_W'(BURST_BYTES * 8);
   localparam logic [10:0] TICK_LAST = 11'(TICK_CYC - 1);

   // slot 0..3 of the code pairs for an index, 4 when none
   function automatic logic [2:0] pair_slot(input logic [11:0] idx);
      case (idx)
         IDX_ING_LO: pair_slot = 3'h0;
         IDX_ING_HI: pair_slot = 3'h1;
         IDX_EGR_LO: pair_slot = 3'h2;
         IDX_EGR_HI: pair_slot = 3'h3;
         default: pair_slot = 3'h4;
      endcase
   endfunction

   // code is a real limit at the present line speed
   function automatic logic is_limit(input logic [6:0] c, input logic fast);
      if (fast) begin
         is_limit = (c != CODE_OFF) && (c <= CODE_SUB_MAX);
      end else begin
         is_limit = (c != CODE_OFF) && (c <= CODE_10M_MAX);
      end
   endfunction

   // bits granted per tick for a limiting code
   function automatic logic [CRED_W-1:0] rate_bits(input logic [6:0] c);
      if (c <= CODE_MBPS_MAX) begin
         rate_bits = CRED_W'(c) * CRED_W'(MBPS_BITS);
      end else begin
         rate_bits = CRED_W'(c - CODE_MBPS_MAX) * CRED_W'(SUB_BITS);
      end
   endfunction

   // ****************************************************
   // register state
   // ****************************************************
   logic [6:0] code [NUM_BKT];
   logic [6:0] next_code [NUM_BKT];
   logic egr_en;
   logic next_egr_en;
   logic [3:0] ctrl;
   logic [3:0] next_ctrl;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [11:0] idx;
   logic [2:0] slot;
   logic mapped;
   logic [15:0] rword;
   logic wr_go;
   logic acc;

   assign idx = paddr[IDX_LSB +: 12];
   assign slot = pair_slot(idx);
   assign mapped = (paddr[IDX_LSB-1:0] == 2'h0) && (slot != 3'h4 || idx == IDX_CTRL);
   assign acc = psel && penable && !pready;
   assign wr_go = psel && penable && pready && pwrite && !pslverr;

   // read word: reserved bits 15 and 7 read zero except the egress enable
   always_comb begin
      rword = 16'h0000;
      if (idx == IDX_CTRL) begin
         rword[3:0] = ctrl;
      end else if (slot != 3'h4) begin
         rword[HI_LSB +: CODE_W] = code[{slot[1:0], 1'b1}];
         rword[LO_LSB +: CODE_W] = code[{slot[1:0], 1'b0}];
         rword[EGR_EN_BIT] = (slot == 3'h2) && egr_en;
      end
   end

   // apb: one wait state, writes land on the ready edge
   always_comb begin
      next_pready = acc;
      next_pslverr = acc && !mapped;
      next_prdata = prdata;
      if (acc) begin
         next_prdata = (mapped && !pwrite) ? {16'h0000, rword} : 32'h0000_0000;
      end
      next_code = code;
      next_egr_en = egr_en;
      next_ctrl = ctrl;
      if (wr_go && idx == IDX_CTRL && pstrb[0]) begin
         next_ctrl = pwdata[3:0];
      end
      if (wr_go && slot != 3'h4) begin
         if (pstrb[0]) begin
            next_code[{slot[1:0], 1'b0}] = pwdata[LO_LSB +: CODE_W];
         end
         if (pstrb[1]) begin
            next_code[{slot[1:0], 1'b1}] = pwdata[HI_LSB +: CODE_W];
         end
         if (pstrb[0] && slot == 3'h2) begin
            next_egr_en = pwdata[EGR_EN_BIT];
         end
      end
   end

   // every code field resets to zero
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_BKT; i++) begin
            code[i] <= CODE_OFF;
         end
         egr_en <= 1'b0;
         ctrl <= CTRL_RESET;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         code <= next_code;
         egr_en <= next_egr_en;
         ctrl <= next_ctrl;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ****************************************************
   // refill tick divider
   // ****************************************************
   logic [10:0] tick_cnt;
   logic [10:0] next_tick_cnt;
   logic tick;

   assign tick = (tick_cnt == TICK_LAST);

   always_comb begin
      next_tick_cnt = tick ? 11'h000 : tick_cnt + 11'h001;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tick_cnt <= 11'h000;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // ****************************************************
   // frame cost and counting selection
   // ****************************************************
   logic [15:0] ing_cost;
   logic [15:0] egr_cost;
   logic ing_counted;
   prl_mode_e mode;

   assign mode = prl_mode_e'(ctrl[MODE_LSB +: 2]);

   // gap and preamble bytes added per frame
   function automatic logic [15:0] cost_bits(input logic [11:0] len, input logic [3:0] c);
      logic [12:0] bytes;
      bytes = {1'b0, len};
      if (c[IFG_BIT]) begin
         bytes = bytes + 13'(IFG_BYTES);
      end
      if (c[PRE_BIT]) begin
         bytes = bytes + 13'(PRE_BYTES);
      end
      cost_bits = {bytes, 3'h0};
   endfunction

   assign ing_cost = cost_bits(ing_frame.len, ctrl);
   assign egr_cost = cost_bits(egr_frame.len, ctrl);

   // which ingress frames meet the meter
   always_comb begin
      case (mode)
         LIM_ALL: ing_counted = 1'b1;
         LIM_BMF: ing_counted = ing_frame.bcast || ing_frame.mcast || ing_frame.flood;
         LIM_BM: ing_counted = ing_frame.bcast || ing_frame.mcast;
         LIM_B: ing_counted = ing_frame.bcast;
         default: ing_counted = 1'b1;
      endcase
   end

   // ****************************************************
   // credit meters, bucket b: direction b[2], priority b[1:0]
   // ****************************************************
   logic [CRED_W-1:0] credit [NUM_BKT];
   logic [CRED_W-1:0] next_credit [NUM_BKT];
   logic [NUM_BKT-1:0] active;
   logic [NUM_BKT-1:0] hit;
   logic [NUM_BKT-1:0] short;
   prl_verdict_s next_ing_verdict;
   prl_verdict_s next_egr_verdict;

   for (genvar b = 0; b < NUM_BKT; b++) begin : g_bkt
      logic [CRED_W:0] sum;
      logic [15:0] cost;
      // egress meters run only while enabled
      assign active[b] = is_limit(code[b], speed_100) && ((b < NUM_PRIO) || egr_en);
      assign cost = (b < NUM_PRIO) ? ing_cost : egr_cost;
      assign hit[b] = (b < NUM_PRIO) ?
         (ing_frame.valid && ing_counted && ing_frame.prio == 2'(b)) :
         (egr_frame.valid && egr_frame.prio == 2'(b - NUM_PRIO));
      assign short[b] = active[b] && hit[b] && (credit[b] < CRED_W'(cost));
      // refill at the rate, spend on each passed frame
      always_comb begin
         sum = {1'b0, credit[b]};
         if (tick) begin
            sum = sum + {1'b0, rate_bits(code[b])};
         end
         if (active[b] && hit[b] && !short[b]) begin
            sum = sum - (CRED_W+1)'(cost);
         end
         if (!active[b] || sum > {1'b0, CAP}) begin
            // idle meters stay full so a new limit starts with a full burst
            next_credit[b] = CAP;
         end else begin
            next_credit[b] = sum[CRED_W-1:0];
         end
      end
   end

   // drop a frame whose meter lacks credit
   always_comb begin
      next_ing_verdict.valid = ing_frame.valid;
      next_ing_verdict.pass = !(|short[NUM_PRIO-1:0]);
      next_ing_verdict.metered = |(hit[NUM_PRIO-1:0] & active[NUM_PRIO-1:0]);
      next_egr_verdict.valid = egr_frame.valid;
      next_egr_verdict.pass = !(|short[NUM_BKT-1:NUM_PRIO]);
      next_egr_verdict.metered = |(hit[NUM_BKT-1:NUM_PRIO] & active[NUM_BKT-1:NUM_PRIO]);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_BKT; i++) begin
            credit[i] <= CAP;
         end
         ing_verdict <= '0;
         egr_verdict <= '0;
      end else begin
         credit <= next_credit;
         ing_verdict <= next_ing_verdict;
         egr_verdict <= next_egr_verdict;
      end
   end
endmodule

/* prl_rate_limit_chk.sv */
/*
 checker of the rate limiter ports: apb answer timing, refusals, verdicts.
 assumes a bind onto prl_rate_limit made from the bench top file.
*/
`timescale 1ns/1ns
module prl_rate_limit_chk
   import prl_pkg::*;
#(
   parameter int unsigned ADDR_W = 14
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic speed_100,
   input wire prl_frame_s ing_frame,
   input wire prl_frame_s egr_frame,
   input wire prl_verdict_s ing_verdict,
   input wire prl_verdict_s egr_verdict
);
   // decoded index; address is still held while pready is high
   wire logic [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
   wire logic hit = paddr[1:0] == 2'h0 && idx inside {IDX_CTRL, IDX_ING_LO, IDX_ING_HI,
      IDX_EGR_LO, IDX_EGR_HI};
   wire logic rsv = idx inside {IDX_ING_LO, IDX_ING_HI, IDX_EGR_HI};
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ****************
   // assertions
   // ****************
   AST_ONE_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_REFUSE: assert property (pready && !hit |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property (pready && hit |-> !pslverr)
      else $error("mapped access refused");
   AST_RSV_ZERO: assert property (pready && !pwrite && hit && rsv |->
      prdata[31:15] == 17'h0 && !prdata[7])
      else $error("reserved bits read nonzero");
   AST_ING_ANSWER: assert property (ing_frame.valid |=> ing_verdict.valid)
      else $error("ingress verdict missing");
   AST_EGR_ANSWER: assert property (egr_verdict.valid |-> $past(egr_frame.valid))
      else $error("egress verdict without frame");
   AST_ING_FREE: assert property (ing_verdict.valid && !ing_verdict.metered |-> ing_verdict.pass)
      else $error("unmetered ingress frame dropped");
   AST_EGR_FREE: assert property (egr_verdict.valid && !egr_verdict.metered |-> egr_verdict.pass)
      else $error("unmetered egress frame dropped");
   // main scenarios
   COV_DROP: cover property (ing_verdict.valid && !ing_verdict.pass);
   COV_EGR_METER: cover property (egr_verdict.valid && egr_verdict.metered);
   COV_REFUSE: cover property (pready && pslverr);
endmodule

/* tb_prl_rate_limit.sv */
/*
 bench of prl_rate_limit: register access over apb and frame verdicts.
 assumes the checker is compiled first; burst depth cut to 64 bytes.
*/
`timescale 1ns/1ns
module tb_prl_rate_limit
   import prl_pkg::*;
;
   localparam int BURST = 64;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [13:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'h3;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic speed_100 = 1'b1;
   prl_frame_s ing_frame = '0;
   prl_frame_s egr_frame = '0;
   prl_verdict_s ing_verdict;
   prl_verdict_s egr_verdict;
   logic [33:0] apb_q[$];
   logic [2:0] vrd_q[$];
   int num_errors = 0;
   int cmp_count = 0;
   logic [15:0] rnd = 16'h005c;
   logic [11:0] a;
   logic [15:0] en;
   logic [11:0] idx_tab[5] = '{IDX_CTRL, IDX_ING_LO, IDX_ING_HI, IDX_EGR_LO, IDX_EGR_HI};
   logic [15:0] msk_tab[5] = '{16'h000f, 16'h7f7f, 16'h7f7f, 16'h7fff, 16'h7f7f};
   // small codes only: larger ones could refill the bucket between frames
   logic [6:0] cod_tab[4] = '{7'h01, 7'h04, 7'h65, 7'h73};
   logic [11:0] len_tab[3] = '{12'd44, 12'd52, 12'd56};

   always #50 clk = !clk;

   prl_rate_limit #(.BURST_BYTES(BURST), .CRED_W(20)) dut_u (.clk(clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .speed_100(speed_100), .ing_frame(ing_frame), .egr_frame(egr_frame),
      .ing_verdict(ing_verdict), .egr_verdict(egr_verdict));

   // ****************
   // tasks
   // ****************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic stop_test();
      if (apb_q.size() != 0 || vrd_q.size() != 0) num_errors++;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // exp is {is_read, slverr, data}
   task automatic cmp_apb(input logic [33:0] exp);
      cmp_count++;
      if (pslverr !== exp[32] || (exp[33] && prdata !== exp[31:0])) begin
         num_errors++;
         $display("Error %0t: got %h %h exp %h", $time, pslverr, prdata, exp);
      end
   endtask

   task automatic cmp_vrd(input logic [2:0] got);
      logic [2:0] exp;
      exp = vrd_q.pop_front();
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [13:0] ad, input logic [15:0] d,
         input logic [33:0] exp);
      apb_q.push_back(exp);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] i, input logic [15:0] d);
      apb(1'b1, {i, 2'b00}, d, 34'h0);
   endtask

   task automatic rd(input logic [11:0] i, input logic [15:0] v);
      apb(1'b0, {i, 2'b00}, 16'h0, {2'b10, 16'h0, v});
   endtask

   // k is {bcast, mcast, flood}, exp is {pass, metered}
   task automatic frm(input logic e, input logic [1:0] p, input logic [11:0] len,
         input logic [2:0] k, input logic [1:0] exp);
      vrd_q.push_back({e, exp});
      if (e) egr_frame <= {1'b1, p, len, k};
      else ing_frame <= {1'b1, p, len, k};
      @(posedge clk);
      ing_frame <= '0;
      egr_frame <= '0;
      @(posedge clk);
   endtask

   // result watcher: takes the oldest note as each answer shows
   always @(posedge clk) begin
      if (pready === 1'b1) cmp_apb(apb_q.pop_front());
      if (ing_verdict.valid === 1'b1) cmp_vrd({1'b0, ing_verdict.pass, ing_verdict.metered});
      if (egr_verdict.valid === 1'b1) cmp_vrd({1'b1, egr_verdict.pass, egr_verdict.metered});
   end

   initial begin
      #3000000;
      num_errors++;
      stop_test();
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         rd(idx_tab[i], 16'h0000);
         rnd = lfsr(rnd);
         wr(idx_tab[i], rnd);
         rd(idx_tab[i], rnd & msk_tab[i]);
         wr(idx_tab[i], 16'h0000);
      end
      apb(1'b0, 14'h1f0, 16'h0, {2'b11, 32'h0});
      apb(1'b1, {IDX_ING_LO, 2'b10}, 16'h0001, {2'b01, 32'h0});
      rd(IDX_ING_LO, 16'h0000);
      // lane 1 strobe low: the priority 1 field must keep its old value
      pstrb <= 4'h1;
      wr(IDX_ING_LO, 16'h7f7f);
      pstrb <= 4'h3;
      rd(IDX_ING_LO, 16'h007f);
      wr(IDX_ING_LO, 16'h0000);
      $display("test registers done");
      for (int e = 0; e < 2; e++) begin
         for (int i = 0; i < 4; i++) begin
            a = (e ? IDX_EGR_LO : IDX_ING_LO) + 12'(2 * (i / 2));
            en = (e && i < 2) ? 16'h0080 : 16'h0000;
            if (e) wr(IDX_EGR_LO, 16'h0080);
            wr(a, en | (16'(cod_tab[i]) << (8 * (i % 2))));
            frm(1'(e), 2'(i), 12'd64, 3'h0, 2'b11);
            frm(1'(e), 2'(i), 12'd64, 3'h0, 2'b01);
            wr(a, en);
            frm(1'(e), 2'(i), 12'd64, 3'h0, 2'b10);
         end
      end
      wr(IDX_EGR_LO, 16'h0001);
      frm(1'b1, 2'd0, 12'd64, 3'h0, 2'b10);
      frm(1'b1, 2'd0, 12'd64, 3'h0, 2'b10);
      wr(IDX_EGR_LO, 16'h0000);
      $display("test meters done");
      speed_100 <= 1'b0;
      wr(IDX_ING_HI, 16'h0300);
      frm(1'b0, 2'd3, 12'd64, 3'h0, 2'b11);
      frm(1'b0, 2'd3, 12'd64, 3'h0, 2'b01);
      wr(IDX_ING_HI, 16'h0000);
      // code ten still limits at 10 Mbit/s, code eleven does not
      wr(IDX_ING_HI, 16'h0a0b);
      frm(1'b0, 2'd3, 12'd64, 3'h0, 2'b11);
      frm(1'b0, 2'd2, 12'd64, 3'h0, 2'b10);
      wr(IDX_ING_HI, 16'h0000);
      speed_100 <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(IDX_CTRL, 16'(3 - i));
         wr(IDX_ING_LO, 16'h0001);
         frm(1'b0, 2'd0, len_tab[i] + 12'd1, 3'h0, 2'b01);
         frm(1'b0, 2'd0, len_tab[i], 3'h0, 2'b11);
         wr(IDX_ING_LO, 16'h0000);
      end
      wr(IDX_ING_LO, 16'h0001);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_CTRL, 16'(m << 2));
         for (int k = 0; k < 4; k++) begin
            frm(1'b0, 2'd0, 12'd1, k == 0 ? 3'h0 : 3'(1 << (k - 1)), {1'b1, k >= m});
         end
      end
      $display("test modes done");
      // a mid-run reset must clear the control, ingress low and egress low fields written above
      wr(IDX_EGR_LO, 16'h0080);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(IDX_CTRL, 16'h0000);
      rd(IDX_ING_LO, 16'h0000);
      rd(IDX_EGR_LO, 16'h0000);
      $display("test reset done");
      stop_test();
   end
endmodule

bind prl_rate_limit prl_rate_limit_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .reset(reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .speed_100(speed_100), .ing_frame(ing_frame), .egr_frame(egr_frame),
   .ing_verdict(ing_verdict), .egr_verdict(egr_verdict));
